//--- hw/fept_timer.sv
// falling-edge timer with register port and synchronised control pins
//
// Contract
// - a run starts on a one-to-zero trigger transition, or on enable or reset rising while trigger is low.
// - tick period selectable 1, 10, 100, 1000, 10000 ms; accumulator steps per tick.
// - terminal count is an integer 0 through 32767.
// - run start clears accumulator, then increments per tick up to terminal count.
// - at terminal count counting stops and accumulator holds until next start or a low reset input.
// - standard output is one while counting, zero otherwise.
// - inverted output is zero while counting, one otherwise.
// - after terminal count the output stays inactive until a fresh run.
// - reset input is active low; while low timing is halted.
// - enable input allows output updates; disabled suppresses them.
// - disabled finishes running count, freezes output; re-enable acts at once.
// - trigger low when enable rises counts as a falling edge.
// - reset falling during a run stops timer, output goes inactive.
// - reset rising with trigger low starts a run; with trigger high not.
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`include "fept_defines.svh"

module fept_timer #(
    parameter logic [15:0] BASE_TICK_CYCLES = 16'(`FEPT_BASE_TICK_CYC)
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic blk_enable,
    input wire logic blk_trigger,
    input wire logic blk_reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic timer_out
);

    // ======================================================================
    // helpers
    function automatic logic [13:0] unit_last(input logic [2:0] sel);
        case (fept_pkg::fept_unit_t'(sel))
            fept_pkg::FEPT_UNIT_1MS: unit_last = `FEPT_UNIT_LAST_1MS;
            fept_pkg::FEPT_UNIT_10MS: unit_last = `FEPT_UNIT_LAST_10MS;
            fept_pkg::FEPT_UNIT_100MS: unit_last = `FEPT_UNIT_LAST_100MS;
            fept_pkg::FEPT_UNIT_1000MS: unit_last = `FEPT_UNIT_LAST_1000MS;
            fept_pkg::FEPT_UNIT_10000MS: unit_last = `FEPT_UNIT_LAST_10000MS;
            // unused codes fall back to the shortest unit
            default: unit_last = `FEPT_UNIT_LAST_1MS;
        endcase
    endfunction : unit_last

    // ======================================================================
    // state
    fept_pkg::fept_state_t st_q;
    fept_pkg::fept_state_t st_d;
    logic fall;
    logic en_rise;
    logic rin_rise;
    logic start;
    logic ms_tick;
    logic unit_tick;
    logic [14:0] acc_inc;

    always_comb begin
        st_d = st_q;
        // two-flop synchronisers; only the second stage is read
        st_d.en_m = blk_enable;
        st_d.en_s = st_q.en_m;
        st_d.trig_m = blk_trigger;
        st_d.trig_s = st_q.trig_m;
        st_d.rin_m = blk_reset_n;
        st_d.rin_s = st_q.rin_m;
        st_d.en_prev = st_q.en_s;
        st_d.trig_prev = st_q.trig_s;
        st_d.rin_prev = st_q.rin_s;

        fall = st_q.trig_prev & ~st_q.trig_s;
        en_rise = st_q.en_s & ~st_q.en_prev;
        rin_rise = st_q.rin_s & ~st_q.rin_prev;
        // enable or reset release with trigger already low acts as an edge
        start = st_q.en_s & st_q.rin_s
            & (fall | ((en_rise | rin_rise) & ~st_q.trig_s));

        ms_tick = st_q.counting && (st_q.ms_cnt == BASE_TICK_CYCLES - 16'h0001);
        unit_tick = ms_tick && (st_q.unit_cnt == unit_last(st_q.unit_sel));
        acc_inc = 15'(st_q.acc + 15'h0001);

        // a run in progress continues while disabled
        if (st_q.counting) begin
            if (ms_tick) begin
                st_d.ms_cnt = 16'h0000;
                st_d.unit_cnt = unit_tick ? 14'h0000 : 14'(st_q.unit_cnt + 14'h0001);
            end else begin
                st_d.ms_cnt = 16'(st_q.ms_cnt + 16'h0001);
            end
            if (unit_tick) begin
                st_d.acc = acc_inc;
                if (acc_inc == st_q.limit) begin
                    st_d.counting = 1'b0;
                end
            end
        end

        if (start) begin
            st_d.acc = 15'h0000;
            st_d.ms_cnt = 16'h0000;
            st_d.unit_cnt = 14'h0000;
            st_d.counting = (st_q.limit != 15'h0000);
        end

        // halted reset input wins over everything in flight
        if (!st_q.rin_s) begin
            st_d.counting = 1'b0;
            st_d.acc = 15'h0000;
            st_d.ms_cnt = 16'h0000;
            st_d.unit_cnt = 14'h0000;
        end

        // output follows the run only while enabled
        if (st_q.en_s) begin
            st_d.out = st_d.counting ^ st_q.inv;
        end

        // register writes
        if (reg_wr) begin
            case (reg_addr)
                `FEPT_ADDR_CTRL: begin
                    st_d.unit_sel = reg_wdata[`FEPT_CTRL_UNIT_MSB:`FEPT_CTRL_UNIT_LSB];
                    st_d.inv = reg_wdata[`FEPT_CTRL_INV_BIT];
                end
                `FEPT_ADDR_LIMIT: begin
                    st_d.limit = reg_wdata[`FEPT_LIMIT_MSB:0];
                end
                default: begin
                end
            endcase
        end

        // read data stands only in the cycle after the strobe
        st_d.rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                `FEPT_ADDR_CTRL: begin
                    st_d.rdata[`FEPT_CTRL_UNIT_MSB:`FEPT_CTRL_UNIT_LSB] = st_q.unit_sel;
                    st_d.rdata[`FEPT_CTRL_INV_BIT] = st_q.inv;
                end
                `FEPT_ADDR_LIMIT: st_d.rdata[`FEPT_LIMIT_MSB:0] = st_q.limit;
                `FEPT_ADDR_STATUS: begin
                    st_d.rdata[`FEPT_STAT_COUNTING_BIT] = st_q.counting;
                    st_d.rdata[`FEPT_STAT_OUT_BIT] = st_q.out;
                    st_d.rdata[`FEPT_STAT_EN_BIT] = st_q.en_s;
                    st_d.rdata[`FEPT_STAT_TRIG_BIT] = st_q.trig_s;
                    st_d.rdata[`FEPT_STAT_RIN_BIT] = st_q.rin_s;
                end
                `FEPT_ADDR_ACC: st_d.rdata[14:0] = st_q.acc;
                default: st_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.unit_sel <= `FEPT_UNIT_RST;
            st_q.limit <= `FEPT_LIMIT_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata;
    assign timer_out = st_q.out;

    // ======================================================================
    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    run_start_cause_a: assert property (
        $rose(st_q.counting) |-> $past(start))
        else $error("run began without a start condition");

    acc_step_a: assert property (
        (st_q.acc != $past(st_q.acc)) && (st_q.acc != 15'h0000) |-> $past(unit_tick))
        else $error("accumulator moved without a unit tick");

    start_clear_a: assert property (
        start && st_q.rin_s |=> (st_q.acc == 15'h0000) && (st_q.ms_cnt == 16'h0000))
        else $error("start did not clear accumulator and prescaler");

    limit_stop_a: assert property (
        st_q.counting && unit_tick && (acc_inc == st_q.limit) && !start && st_q.rin_s
        |=> !st_q.counting && (st_q.acc == $past(st_q.limit)))
        else $error("run did not stop at the terminal count");

    hold_count_a: assert property (
        !st_q.counting && !start && st_q.rin_s |=> $stable(st_q.acc) && !st_q.counting)
        else $error("idle accumulator changed without a start");

    // compare against the registered run state, not the next-state logic it came from
    out_level_a: assert property (
        st_q.en_s |=> (timer_out == (st_q.counting ^ $past(st_q.inv))))
        else $error("enabled output does not follow counting and polarity");

    frozen_out_a: assert property (
        !st_q.en_s |=> $stable(timer_out))
        else $error("output changed while disabled");

    // one cycle only: a release with trigger low may legally restart the cycle after
    reset_halt_a: assert property (
        !st_q.rin_s && st_q.en_s |=> !st_q.counting && (timer_out == $past(st_q.inv)))
        else $error("reset input did not halt the run");

    zero_limit_a: assert property (
        start && st_q.rin_s && (st_q.limit == 15'h0000) |=> !st_q.counting)
        else $error("zero terminal count started counting");

endmodule : fept_timer

//--- hw/fept_defines.svh
// offsets, field positions, reset values and timing counts of the falling-edge timer
`ifndef FEPT_DEFINES_SVH
`define FEPT_DEFINES_SVH

// ==========================================================================
// clock and time base
`define FEPT_CLK_KHZ 40000
`define FEPT_BASE_TICK_MS 1
`define FEPT_BASE_TICK_CYC (`FEPT_BASE_TICK_MS * `FEPT_CLK_KHZ)
// last count of the decade divider for each unit
`define FEPT_UNIT_LAST_1MS 14'h0000
`define FEPT_UNIT_LAST_10MS 14'h0009
`define FEPT_UNIT_LAST_100MS 14'h0063
`define FEPT_UNIT_LAST_1000MS 14'h03E7
`define FEPT_UNIT_LAST_10000MS 14'h270F

// ==========================================================================
// register offsets
`define FEPT_ADDR_CTRL 8'h00
`define FEPT_ADDR_LIMIT 8'h04
`define FEPT_ADDR_STATUS 8'h08
`define FEPT_ADDR_ACC 8'h0C

// ==========================================================================
// field positions and reset values
`define FEPT_CTRL_UNIT_LSB 0
`define FEPT_CTRL_UNIT_MSB 2
`define FEPT_CTRL_INV_BIT 3
`define FEPT_LIMIT_MSB 14
`define FEPT_UNIT_RST 3'h0
`define FEPT_LIMIT_RST 15'h0000
`define FEPT_STAT_COUNTING_BIT 0
`define FEPT_STAT_OUT_BIT 1
`define FEPT_STAT_EN_BIT 2
`define FEPT_STAT_TRIG_BIT 3
`define FEPT_STAT_RIN_BIT 4

`endif

//--- hw/fept_pkg.sv
// types of the falling-edge timer
package fept_pkg;

    // ======================================================================
    // selectable time units
    typedef enum logic [2:0] {
        FEPT_UNIT_1MS = 3'h0,
        FEPT_UNIT_10MS = 3'h1,
        FEPT_UNIT_100MS = 3'h2,
        FEPT_UNIT_1000MS = 3'h3,
        FEPT_UNIT_10000MS = 3'h4
    } fept_unit_t;

    // ======================================================================
    // complete state of the timer
    typedef struct packed {
        logic en_m;
        logic en_s;
        logic en_prev;
        logic trig_m;
        logic trig_s;
        logic trig_prev;
        logic rin_m;
        logic rin_s;
        logic rin_prev;
        logic [2:0] unit_sel;
        logic inv;
        logic [14:0] limit;
        logic counting;
        logic [14:0] acc;
        logic [15:0] ms_cnt;
        logic [13:0] unit_cnt;
        logic out;
        logic [31:0] rdata;
    } fept_state_t;

endpackage : fept_pkg

//--- tb/fept_pin_src.sv
// pin-side source model: island inputs and fieldbus bits driving the timer
`timescale 1ns/10ps
module fept_pin_src (
    input wire logic core_clk,
    input wire logic slow,
    input wire logic en_cmd,
    input wire logic trig_cmd,
    input wire logic rst_cmd,
    output logic blk_enable,
    output logic blk_trigger,
    output logic blk_reset_n
);
    logic [2:0] en_q;
    logic [2:0] trig_q;
    logic [2:0] rst_q;
    // trigger starts high so the first enable is not taken as an edge
    initial begin
        en_q = 3'h7;
        trig_q = 3'h7;
        rst_q = 3'h7;
    end
    always @(posedge core_clk) begin
        en_q <= {en_q[1:0], en_cmd};
        trig_q <= {trig_q[1:0], trig_cmd};
        rst_q <= {rst_q[1:0], rst_cmd};
    end
    // slow source: two cycles more, like a filtered field input
    assign blk_enable = slow ? en_q[2] : en_q[0];
    assign blk_trigger = slow ? trig_q[2] : trig_q[0];
    assign blk_reset_n = slow ? rst_q[2] : rst_q[0];
endmodule : fept_pin_src

//--- tb/fept_timer_tb_top.sv
// self-checking bench of the falling-edge timer
`timescale 1ns/10ps
module fept_timer_tb_top;
    localparam logic [15:0] BASE = 16'h0004;
    logic core_clk, rst_n, reg_wr, reg_rd, en_c, trig_c, rst_c, slow;
    logic blk_enable, blk_trigger, blk_reset_n, timer_out;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d, seed;
    logic [14:0] lim;
    int n_errors, checks, cyc, n;
    fept_timer #(.BASE_TICK_CYCLES(BASE)) dut (.core_clk(core_clk), .rst_n(rst_n),
        .blk_enable(blk_enable), .blk_trigger(blk_trigger), .blk_reset_n(blk_reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .timer_out(timer_out));
    fept_pin_src pins (.core_clk(core_clk), .slow(slow), .en_cmd(en_c), .trig_cmd(trig_c),
        .rst_cmd(rst_c), .blk_enable(blk_enable), .blk_trigger(blk_trigger),
        .blk_reset_n(blk_reset_n));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // ======================================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic int run_len(input logic [2:0] u, input logic [14:0] l);
        int m;
        m = 1;
        for (int i = 0; i < 5; i++) if (i < u) m = m * 10;
        return l * m * BASE;
    endfunction : run_len
    task stop_test;
        if (n_errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        v = reg_rdata;
    endtask : rd
    // pins settle through model and synchronisers, so give them time
    task pin(input logic e, input logic t, input logic r, input int w);
        @(posedge core_clk);
        en_c <= e;
        trig_c <= t;
        rst_c <= r;
        repeat (w) @(posedge core_clk);
    endtask : pin
    task measure(input logic act, output int len);
        int w;
        w = 0;
        len = 0;
        while (timer_out !== act && w < 14) begin
            @(posedge core_clk);
            w++;
        end
        while (timer_out === act && len < 50000) begin
            @(posedge core_clk);
            len++;
        end
    endtask : measure
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 99000) begin
            n_errors++;
            stop_test();
        end
    end
    // ======================================================================
    // main sequence
    initial begin
        {rst_n, reg_wr, reg_rd, slow} = 4'h0;
        {en_c, trig_c, rst_c} = 3'h7;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        {n_errors, checks, cyc} = '0;
        seed = 32'hfeea;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(8'h00, d); chk(d, 32'h0, "ctrl reset");
        rd(8'h04, d); chk(d, 32'h0, "limit reset");
        seed = lfsr(seed);
        wr(8'h0C, seed); rd(8'h0C, d); chk(d, 32'h0, "acc write");
        rd(8'h10, d); chk(d, 32'h0, "unmapped");
        wr(8'h04, 32'hFFFF); rd(8'h04, d); chk(d, 32'h7FFF, "limit max");
        for (int u = 0; u < 5; u++) begin
            seed = lfsr(seed);
            lim = (u == 4) ? 15'h0001 : 15'(seed[1:0] % 3 + 1);
            slow <= seed[2];
            wr(8'h00, 32'(u));
            wr(8'h04, {17'h0, lim});
            pin(1'b1, 1'b0, 1'b1, 0);
            measure(1'b1, n); chk(32'(n), 32'(run_len(3'(u), lim)), "run len");
            rd(8'h0C, d); chk(d, {17'h0, lim}, "acc at end");
            pin(1'b1, 1'b1, 1'b1, 0);
            measure(1'b1, n); chk(32'(n), 32'h0, "rise start");
            rd(8'h0C, d); chk(d, {17'h0, lim}, "acc kept");
        end
        slow <= 1'b0;
        wr(8'h00, 32'h8);
        wr(8'h04, 32'h3);
        repeat (4) @(posedge core_clk);
        chk({31'h0, timer_out}, 32'h1, "inv idle");
        pin(1'b1, 1'b0, 1'b1, 0);
        measure(1'b0, n); chk(32'(n), 32'hC, "inv run");
        repeat (20) @(posedge core_clk);
        chk({31'h0, timer_out}, 32'h1, "inv after");
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h0);
        pin(1'b1, 1'b1, 1'b1, 8);
        pin(1'b1, 1'b0, 1'b1, 0);
        measure(1'b1, n); chk(32'(n), 32'h0, "zero limit");
        wr(8'h04, 32'd20);
        pin(1'b1, 1'b1, 1'b1, 8);
        pin(1'b1, 1'b0, 1'b1, 20);
        rd(8'h08, d); chk({31'h0, d[0]}, 32'h1, "counting");
        chk({28'h0, d[4:1]}, 32'hB, "status pins");
        @(posedge core_clk);
        chk(reg_rdata, 32'h0, "rdata stands");
        pin(1'b1, 1'b0, 1'b0, 8);
        chk({31'h0, timer_out}, 32'h0, "reset stop");
        rd(8'h0C, d); chk(d, 32'h0, "reset acc");
        pin(1'b1, 1'b0, 1'b1, 0);
        measure(1'b1, n); chk(32'(n), 32'd80, "reset rise");
        pin(1'b1, 1'b1, 1'b0, 8);
        pin(1'b1, 1'b1, 1'b1, 0);
        measure(1'b1, n); chk(32'(n), 32'h0, "reset trig hi");
        wr(8'h04, 32'd10);
        pin(1'b1, 1'b0, 1'b1, 10);
        pin(1'b0, 1'b1, 1'b1, 60);
        chk({31'h0, timer_out}, 32'h1, "frozen");
        rd(8'h08, d); chk({31'h0, d[0]}, 32'h0, "run done");
        pin(1'b1, 1'b1, 1'b1, 8);
        chk({31'h0, timer_out}, 32'h0, "re-enable");
        pin(1'b0, 1'b0, 1'b1, 8);
        pin(1'b1, 1'b0, 1'b1, 0);
        measure(1'b1, n); chk(32'(n), 32'd40, "enable start");
        stop_test();
    end
endmodule : fept_timer_tb_top
